/* File: hdl/sram_port_map.svh */
// timing counts and widths for the static ram port controller
`ifndef SRAM_PORT_MAP_SVH
`define SRAM_PORT_MAP_SVH
`define CLK_PERIOD_NS 10
`define ADDR_W 15
`define DATA_W 8
`define ADDRESS_ACCESS_TIME_NS 70
`define OE_ACCESS_TIME_NS 35
`define ADDRESS_HOLD_OUT_TIME_NS 10
`define STROBE_TO_FLOAT_TIME_NS 25
`define WRITE_CYCLE_NS 70
`define STROBE_LOW_NS 50
`define SELECT_LOW_NS 55
`define ADDR_TO_END_NS 60
`define DATA_SETUP_NS 30
`define DATA_HOLD_NS 5
`define POWER_UP_HOLDOFF_MS 200
// least times round up, at least one cycle
`define READ_CYC ((`ADDRESS_ACCESS_TIME_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define STROBE_CYC ((`SELECT_LOW_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define HOLD_CYC ((`DATA_HOLD_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
// holdoff wait is the longest recovery, so data are never offered early
`define HOLDOFF_CYC (`POWER_UP_HOLDOFF_MS*100000)
`endif

/* File: hdl/sram_port_pkg.sv */
// types for the static ram port controller
package sram_port_pkg;
  typedef struct packed {
    logic write;
    logic [14:0] addr;
    logic [7:0] wdata;
  } request_type;
  typedef struct packed {
    logic select_n;
    logic output_drive_n;
    logic store_strobe_n;
    logic [14:0] address_lines;
  } pins_type;
  typedef enum logic [2:0] {
    st_holdoff = 3'b000,
    st_idle = 3'b001,
    st_read = 3'b010,
    st_write = 3'b011,
    st_release = 3'b100
  } state_type;
endpackage

/* File: hdl/holdoff_timer.sv */
// power-up holdoff counter
`timescale 1ns/1ps
`include "sram_port_map.svh"
module holdoff_timer #(
  parameter int unsigned HOLDOFF = `HOLDOFF_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic power_fail_level,
  output logic ready
);
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic ready_r;
  logic ready_nxt;
  // ==========================================
  // restart on every fail, count after release
  always_comb begin
    count_nxt = count_r;
    ready_nxt = ready_r;
    if (power_fail_level) begin
      count_nxt = 32'h0;
      ready_nxt = 1'b0;
    end else if (!ready_r) begin
      if (count_r >= HOLDOFF - 1) begin
        ready_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 32'h1;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_r <= 32'h0;
      ready_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      ready_r <= ready_nxt;
    end
  end
  assign ready = ready_r;
endmodule

/* File: hdl/sram_port_ctrl.sv */
// host-side controller for an asynchronous byte-wide static ram
`timescale 1ns/1ps
`include "sram_port_map.svh"
// Contract
// - write spans later falling edge to first rising edge
// - host keeps address stable across the whole write
// - write data set up 30 ns before end, held 5 ns
// - host keeps output drive high during writes
// - strobe low at least 50 ns, cycle at least 70 ns
// - select-controlled write keeps select low 55 ns
// - address valid 60 ns before the terminating rising edge
// - host keeps select high while supply rises
module sram_port_ctrl
  import sram_port_pkg::*;
#(
  parameter int unsigned HOLDOFF = `HOLDOFF_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic power_fail_level,
  input wire logic req_valid,
  input wire request_type req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic access_blocked,
  output pins_type pins,
  input wire logic [7:0] byte_lanes_in,
  output logic [7:0] byte_lanes_out,
  output logic byte_lanes_oe
);
  localparam logic [3:0] READ_N = 4'(`READ_CYC);
  localparam logic [3:0] STROBE_N = 4'(`STROBE_CYC);
  localparam logic [3:0] HOLD_N = 4'(`HOLD_CYC);

  state_type state_r;
  state_type state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  pins_type pins_r;
  pins_type pins_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rsp_r;
  logic rsp_nxt;
  logic up_ready;
  logic take_write;
  logic read_done;
  logic write_done;
  logic release_done;

  // ==========================================
  // recovery holdoff
  holdoff_timer #(
    .HOLDOFF(HOLDOFF)
  ) u_holdoff (
    .clk_sys(clk_sys),
    .reset(reset),
    .power_fail_level(power_fail_level),
    .ready(up_ready)
  );

  // ==========================================
  // step decode shared by the sequencer and the data groups
  assign take_write = (state_r == st_idle) && req_valid && req.write &&
    !power_fail_level;
  assign read_done = (state_r == st_read) && (cnt_r + 4'h1 >= READ_N);
  assign write_done = (state_r == st_write) && (cnt_r + 4'h1 >= STROBE_N);
  assign release_done = (state_r == st_release) &&
    (cnt_r + 4'h1 >= HOLD_N);

  // ==========================================
  // access sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pins_nxt = pins_r;
    case (state_r)
      st_holdoff: begin
        // select held high until supply is stable
        pins_nxt.select_n = 1'b1;
        pins_nxt.output_drive_n = 1'b1;
        pins_nxt.store_strobe_n = 1'b1;
        if (up_ready && !power_fail_level) begin
          state_nxt = st_idle;
        end
      end
      st_idle: begin
        if (req_valid) begin
          // address set on the same edge as the strobe, zero margin met
          pins_nxt.address_lines = req.addr;
          pins_nxt.select_n = 1'b0;
          cnt_nxt = 4'h0;
          if (req.write) begin
            // strobe and select fall together, device never drives
            pins_nxt.store_strobe_n = 1'b0;
            pins_nxt.output_drive_n = 1'b1;
            state_nxt = st_write;
          end else begin
            pins_nxt.store_strobe_n = 1'b1;
            pins_nxt.output_drive_n = 1'b0;
            state_nxt = st_read;
          end
        end
      end
      st_read: begin
        // sample only after full access time
        cnt_nxt = cnt_r + 4'h1;
        if (read_done) begin
          // address held until lanes sampled
          pins_nxt.select_n = 1'b1;
          pins_nxt.output_drive_n = 1'b1;
          state_nxt = st_release;
          cnt_nxt = 4'h0;
        end
      end
      st_write: begin
        // strobe width of 60 ns covers 50, 55 and 60 ns minimums
        cnt_nxt = cnt_r + 4'h1;
        if (write_done) begin
          // both rise together, one ending edge
          pins_nxt.store_strobe_n = 1'b1;
          pins_nxt.select_n = 1'b1;
          state_nxt = st_release;
          cnt_nxt = 4'h0;
        end
      end
      st_release: begin
        // data and address kept past the end edge
        cnt_nxt = cnt_r + 4'h1;
        if (release_done) begin
          state_nxt = st_idle;
        end
      end
      default: begin
        state_nxt = st_holdoff;
      end
    endcase
    // a fail aborts at once; only the open write may suffer
    if (power_fail_level) begin
      state_nxt = st_holdoff;
      pins_nxt.select_n = 1'b1;
      pins_nxt.output_drive_n = 1'b1;
      pins_nxt.store_strobe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= st_holdoff;
      cnt_r <= 4'h0;
      pins_r <= '{1'b1, 1'b1, 1'b1, 15'h0000};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
    end
  end

  // ==========================================
  // write data; lanes driven from strobe fall to one cycle past its rise
  always_comb begin
    wdata_nxt = wdata_r;
    oe_nxt = oe_r;
    if (power_fail_level || state_r == st_holdoff) begin
      // a cut write lets go of the lanes at once, no contention on return
      oe_nxt = 1'b0;
    end else if (take_write) begin
      wdata_nxt = req.wdata;
      oe_nxt = 1'b1; // data from strobe start, covers setup
    end else if (release_done) begin
      oe_nxt = 1'b0; // held past the ending edge
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wdata_r <= 8'h00;
      oe_r <= 1'b0;
    end else begin
      wdata_r <= wdata_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ==========================================
  // read capture; a fail before the sampling edge leaves floating lanes,
  // so that answer is dropped instead of handed over as data
  always_comb begin
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    if (read_done && !power_fail_level) begin
      rdata_nxt = byte_lanes_in;
      rsp_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
      rsp_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign req_ready = (state_r == st_idle) && !power_fail_level;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;
  assign access_blocked = (state_r == st_holdoff);
  assign pins = pins_r;
  assign byte_lanes_out = wdata_r;
  assign byte_lanes_oe = oe_r;
endmodule

/* File: bench/sram_port_chk.sv */
// port checker for the static ram controller
`timescale 1ns/1ps
module sram_port_chk
  import sram_port_pkg::*;
#(
  parameter int unsigned HOLDOFF = 20
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic power_fail_level,
  input wire logic req_valid,
  input wire request_type req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic access_blocked,
  input wire pins_type pins,
  input wire logic [7:0] byte_lanes_out,
  input wire logic byte_lanes_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic s_n = pins.store_strobe_n;
  // ======
  // pin timing
  sequence take_rd;
    req_valid && req_ready && !req.write;
  endsequence
  sequence take_wr;
    req_valid && req_ready && req.write;
  endsequence
  a_read_pins: assert property (
    take_rd |=> !pins.select_n && !pins.output_drive_n && s_n
  ) else $error("read pins");
  a_write_pins: assert property (
    take_wr |=> !pins.select_n && !s_n && pins.output_drive_n &&
    byte_lanes_oe && byte_lanes_out == $past(req.wdata)
  ) else $error("write pins");
  a_read_answer: assert property (
    take_rd ##1 !power_fail_level [*7] |=> rsp_valid
  ) else $error("no data");
  // an aborted write ends early on purpose, so it is left out here
  a_strobe_width: assert property (
    $rose(s_n) && !power_fail_level |->
    $past(!s_n, 6) && $past(!pins.select_n, 6)
  ) else $error("short write");
  a_data_setup: assert property (
    $rose(s_n) && !power_fail_level |-> $past(byte_lanes_oe, 3) &&
    byte_lanes_out == $past(byte_lanes_out, 3) && byte_lanes_oe ##1
    !byte_lanes_oe
  ) else $error("data timing");
  a_addr_stable: assert property (
    !s_n ##1 !s_n |-> $stable(pins.address_lines)
  ) else $error("addr moved");
  a_fail_abort: assert property (
    power_fail_level |=> pins.select_n && s_n
  ) else $error("no abort");
  a_holdoff_quiet: assert property (
    access_blocked |-> !req_ready && pins.select_n
  ) else $error("not quiet");
endmodule
bind sram_port_ctrl sram_port_chk #(.HOLDOFF(HOLDOFF)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .power_fail_level(power_fail_level),
  .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .access_blocked(access_blocked), .pins(pins),
  .byte_lanes_out(byte_lanes_out), .byte_lanes_oe(byte_lanes_oe));

/* File: bench/sram_dev_model.sv */
// behavioural model of the byte-wide static ram
`timescale 1ns/1ps
module sram_dev_model
  import sram_port_pkg::*;
(
  input wire pins_type pins,
  input wire logic [7:0] lanes_w,
  input wire logic fail,
  output logic [7:0] lanes_r
);
  // ======
  // storage; no pull on the lanes, so released lanes flip
  logic [7:0] mem [32768];
  logic [14:0] wa;
  logic [7:0] wd;
  wire logic wr = !pins.select_n && !pins.store_strobe_n;
  wire logic rd = !pins.select_n && !pins.output_drive_n &&
    pins.store_strobe_n;
  initial lanes_r = 8'h00;
  // latched while writing, so a pin update at the end cannot move it
  always @*
    if (wr) {wa, wd} = {pins.address_lines, lanes_w};
  // protection taken at once, the earliest a fast fall allows
  always @(negedge wr)
    if (!fail) mem[wa] <= wd;
  // junk from the hold time until a little inside the access time, so a
  // host that samples early reads a wrong byte
  realtime t_mark = 0.0;
  always @(pins.address_lines or rd)
    t_mark = $realtime;
  always #1
    if (rd && !fail && $realtime - t_mark >= 10.0)
      lanes_r = $realtime - t_mark >= 65.0 ? mem[pins.address_lines] :
        ~mem[pins.address_lines];
  always @(negedge rd)
    lanes_r <= ~lanes_r;
endmodule

/* File: bench/sram_port_ctrl_tb.sv */
// self-checking bench for the static ram port controller
`timescale 1ns/1ps
module sram_port_ctrl_tb;
  import sram_port_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, power_fail_level = 1'b0;
  logic req_valid = 1'b0, rdy = 1'b0;
  request_type req = '0;
  logic req_ready, rsp_valid, access_blocked, byte_lanes_oe;
  logic [7:0] rsp_rdata, byte_lanes_out, dev_q;
  pins_type pins;
  wire logic [7:0] lanes = byte_lanes_oe ? byte_lanes_out : dev_q;
  logic [7:0] q[$], dat[6];
  logic [14:0] adr[6];
  int seed = 32'hF8B1, failures = 0, samples_checked = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  sram_port_ctrl #(.HOLDOFF(20)) u_sram_port_ctrl (.clk_sys(clk_sys),
    .reset(reset), .power_fail_level(power_fail_level),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins),
    .access_blocked(access_blocked), .byte_lanes_in(lanes),
    .byte_lanes_out(byte_lanes_out), .byte_lanes_oe(byte_lanes_oe));
  sram_dev_model u_sram_dev_model (.pins(pins), .lanes_w(lanes),
    .fail(power_fail_level), .lanes_r(dev_q));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(input logic w, input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{w, a, d};
    do @(posedge clk_sys); while (rdy !== 1'b1);
    req_valid <= 1'b0;
    if (!w) q.push_back(d);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ======
  // watcher: ready sampled mid-cycle, read data against oldest note
  always @(negedge clk_sys) begin
    rdy <= req_ready;
    if (rsp_valid === 1'b1)
      chk("rdata", rsp_rdata, q.size() > 0 ? q.pop_front() : 8'hXX);
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk("holdoff", {6'h00, access_blocked, req_ready}, 8'h02);
    $display("holdoff done");
    foreach (adr[i]) begin
      adr[i] = i == 0 ? 15'h0000 : i == 5 ? 15'h7FFF :
        {3'(i), 12'($random(seed))};
      dat[i] = 8'($random(seed));
      op(1'b1, adr[i], dat[i]);
    end
    foreach (adr[i]) op(1'b0, adr[5 - i], dat[5 - i]);
    $display("write read done");
    op(1'b1, adr[1], ~dat[1]);
    repeat (3) @(posedge clk_sys);
    power_fail_level <= 1'b1;
    repeat (3) @(posedge clk_sys);
    power_fail_level <= 1'b0;
    @(negedge clk_sys);
    chk("fail", {6'h00, access_blocked, req_ready}, 8'h02);
    foreach (adr[i]) if (i != 1) op(1'b0, adr[i], dat[i]);
    $display("power fail done");
    repeat (10) @(posedge clk_sys);
    chk("pending", 8'(q.size()), 8'h00);
    summarize();
  end
endmodule
